/* hw/nvspi_params.svh */
// constants for the serial nonvolatile memory slave
// assumes inclusion by bare name from every design file that needs it
`ifndef NVSPI_PARAMS_SVH
`define NVSPI_PARAMS_SVH

// array geometry
`define NVSPI_ADDR_W      17
`define NVSPI_ADDR_MAX    17'h1FFFF
`define NVSPI_ADDR_ZERO   17'h00000
`define NVSPI_QTR_BASE    17'h18000
`define NVSPI_HALF_BASE   17'h10000
`define NVSPI_ADDR_LAST   2'h2

// status register field positions
`define NVSPI_SR_ZERO_B   0
`define NVSPI_SR_LATCH_B  1
`define NVSPI_SR_BG_LO_B  2
`define NVSPI_SR_BG_HI_B  3
`define NVSPI_SR_ONE_B    6
`define NVSPI_SR_PIN_EN_B 7

// reset and shipped values
`define NVSPI_SR_RESET    8'h40
`define NVSPI_GUARD_INIT  2'h0
`define NVSPI_SYNC_RESET  4'h9

// data path buffering
`define NVSPI_FIFO_DEPTH  16
`define NVSPI_LAST_BIT    3'h7

`endif

/* hw/nvspi_pkg.sv */
// types shared by the serial nonvolatile memory slave
// assumes nothing beyond a SystemVerilog compiler
package nvspi_pkg;

    // command codes carried in the first byte of a select cycle
    typedef enum logic [7:0] {
        OP_NONE          = 8'h00,
        OP_STATUS_WRITE  = 8'h01,
        OP_WRITE         = 8'h02,
        OP_READ          = 8'h03,
        OP_LATCH_CLEAR   = 8'h04,
        OP_STATUS_READ   = 8'h05,
        OP_LATCH_SET     = 8'h06,
        OP_QUICK_READ    = 8'h0B
    } nvspi_op_t;

    // command sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR   = 3'b010,
        ST_DUMMY  = 3'b011,
        ST_WDATA  = 3'b100,
        ST_RDATA  = 3'b101,
        ST_SRDATA = 3'b110,
        ST_SWDATA = 3'b111
    } nvspi_state_t;

endpackage

/* hw/nvspi_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module nvspi_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;
    logic             push;
    logic             pop;

    // honest full and empty from the fill count
    assign in_ready_o  = (count_ff < (PW+1)'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign out_data_o  = store_ff[rd_ptr_ff];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            store_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    // pointers and count
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

/* hw/nvspi_mem.sv */
// byte-wide single-port array with registered read data
// assumes one access per cycle, chosen by the caller
`timescale 1ns/1ps
module nvspi_mem #(
    parameter int ADDR_W = 17
) (
    input  wire logic              clk_i,
    input  wire logic              en_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    output logic      [7:0]        rdata_o
);
    logic [7:0] cell_ff [2**ADDR_W];

    // write at once, read through an output register
    always_ff @(posedge clk_i) begin
        if (en_i && we_i) begin
            cell_ff[addr_i] <= wdata_i;
        end
        if (en_i && !we_i) begin
            rdata_o <= cell_ff[addr_i];
        end
    end
endmodule

/* hw/nvspi_core.sv */
// serial memory slave: command sequencer, protection status, array access
// assumes spi pins arrive asynchronously and are much slower than clk_i
`timescale 1ns/1ps
`include "nvspi_params.svh"

// Summary of operation
// - latch-clear command clears the write latch
// - status bits 0,4,5 zero, bit 6 one
// - status bit 1 mirrors latch, commands only
// - two guard bits choose protected address range
// - guard bits survive reset as nonvolatile
// - bit 7 with low pin blocks status writes
// - guard pin never affects array writes
// - clear latch refuses every write
// - status read repeats one status byte while clocked
// - status write updates 7,3,2, clears latch
// - write: opcode, three address bytes, data
// - each byte committed after eighth bit
// - address increments per byte, wraps to zero
// - burst hitting protected block stops, discards rest
// - chip select rise ends writes, msb first
// - read drives eight clocks per byte, msb first
// - select rise ends read, output released
// - quick read adds one dummy byte
// - serial input ignored while driving data
// - select rise ends quick read, output released
// - fixed opcode encodings
// - latch set by command, cleared at select rise after latch-clear, write or status write
// - only the low seventeen address bits used
// - sample on rising, drive on falling edges
module nvspi_core #(
    parameter int ADDR_W     = `NVSPI_ADDR_W,
    parameter int FIFO_DEPTH = `NVSPI_FIFO_DEPTH
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic spi_sck_i,
    input  wire logic spi_cs_n_i,
    input  wire logic spi_si_i,
    input  wire logic status_guard_n_i,
    output logic      spi_so_o,
    output logic      spi_so_oe_o,
    output logic      wr_overrun_o
);
    localparam int FW = ADDR_W + 8;

    logic [3:0]              sync1_ff;
    logic [3:0]              sync2_ff;
    logic                    sck_d_ff;
    logic                    cs_d_ff;
    nvspi_pkg::nvspi_state_t state_ff;
    logic [7:0]              cmd_ff;
    logic [7:0]              rx_ff;
    logic [2:0]              bitcnt_ff;
    logic [1:0]              acnt_ff;
    logic [ADDR_W-1:0]       addr_ff;
    logic                    latch_ff;
    logic [1:0]              block_guard_ff = `NVSPI_GUARD_INIT;
    logic                    pin_guard_enable_ff = 1'b0;
    logic                    halt_ff;
    logic                    overrun_ff;
    logic                    rd_pend_ff;
    logic                    rd_ack_ff;
    logic [7:0]              tx_buf_ff;
    logic [7:0]              tx_sh_ff;
    logic                    so_ff;
    logic                    so_oe_ff;
    logic                    cs_n_s;
    logic                    sck_s;
    logic                    si_s;
    logic                    wp_n_s;
    logic                    sck_rise;
    logic                    sck_fall;
    logic                    cs_fall;
    logic                    cs_rise;
    logic [7:0]              rx_byte;
    logic                    byte_done;
    logic                    wr_ok;
    logic                    push;
    logic                    sr_write;
    logic [7:0]              status;
    logic                    fifo_in_ready;
    logic                    fifo_out_valid;
    logic [FW-1:0]           fifo_out_data;
    logic                    mem_en;
    logic                    mem_we;
    logic [ADDR_W-1:0]       mem_addr;
    logic [7:0]              mem_rdata;

    // block guard decode: which addresses refuse writes
    function automatic logic guarded(input logic [1:0] bg, input logic [ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        unique case (bg)
            2'h0: hit = 1'b0;
            2'h1: hit = (a >= `NVSPI_QTR_BASE);
            2'h2: hit = (a >= `NVSPI_HALF_BASE);
            2'h3: hit = 1'b1;
        endcase
        return hit;
    endfunction

    // next address with natural wrap at the top of the array
    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
        return (a == `NVSPI_ADDR_MAX) ? `NVSPI_ADDR_ZERO : a + 1'b1;
    endfunction

    // two-stage synchronisers for all pins
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync1_ff <= `NVSPI_SYNC_RESET;
            sync2_ff <= `NVSPI_SYNC_RESET;
        end else begin
            sync1_ff <= {status_guard_n_i, spi_si_i, spi_sck_i, spi_cs_n_i};
            sync2_ff <= sync1_ff;
        end
    end

    assign cs_n_s = sync2_ff[0];
    assign sck_s  = sync2_ff[1];
    assign si_s   = sync2_ff[2];
    assign wp_n_s = sync2_ff[3];

    // edge history of clock and select
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sck_d_ff <= 1'b0;
            cs_d_ff  <= 1'b1;
        end else begin
            sck_d_ff <= sck_s;
            cs_d_ff  <= cs_n_s;
        end
    end

    assign sck_rise  = sck_s && !sck_d_ff && !cs_n_s;
    assign sck_fall  = !sck_s && sck_d_ff && !cs_n_s;
    assign cs_fall   = cs_d_ff && !cs_n_s;
    assign cs_rise   = !cs_d_ff && cs_n_s;
    assign rx_byte   = {rx_ff[6:0], si_s};
    assign byte_done = sck_rise && !cs_fall && (bitcnt_ff == `NVSPI_LAST_BIT);

    // status byte as read back
    always_comb begin
        status                      = `NVSPI_SR_RESET;
        status[`NVSPI_SR_LATCH_B]   = latch_ff;
        status[`NVSPI_SR_BG_LO_B]   = block_guard_ff[0];
        status[`NVSPI_SR_BG_HI_B]   = block_guard_ff[1];
        status[`NVSPI_SR_PIN_EN_B]  = pin_guard_enable_ff;
    end

    // array write gate: latch, guard bits and burst stop only, pin not involved
    assign wr_ok    = latch_ff && !guarded(block_guard_ff, addr_ff) && !halt_ff;
    assign push     = byte_done && (state_ff == nvspi_pkg::ST_WDATA) && wr_ok && fifo_in_ready;
    assign sr_write = byte_done && (state_ff == nvspi_pkg::ST_SWDATA) && latch_ff
                      && !(pin_guard_enable_ff && !wp_n_s);

    // bit sampling on rising clock edges
    always_ff @(posedge clk_i) begin
        if (srst_i || cs_fall) begin
            rx_ff     <= 8'h00;
            bitcnt_ff <= 3'h0;
        end else if (sck_rise) begin
            rx_ff     <= rx_byte;
            bitcnt_ff <= bitcnt_ff + 1'b1;
        end
    end

    // command sequencer
    always_ff @(posedge clk_i) begin
        if (srst_i || cs_n_s) begin
            state_ff <= nvspi_pkg::ST_IDLE;
        end else if (cs_fall) begin
            state_ff <= nvspi_pkg::ST_OPCODE;
        end else if (byte_done) begin
            unique case (state_ff)
                nvspi_pkg::ST_OPCODE: begin
                    unique case (rx_byte)
                        nvspi_pkg::OP_STATUS_READ:  state_ff <= nvspi_pkg::ST_SRDATA;
                        nvspi_pkg::OP_STATUS_WRITE: state_ff <= nvspi_pkg::ST_SWDATA;
                        nvspi_pkg::OP_READ,
                        nvspi_pkg::OP_WRITE,
                        nvspi_pkg::OP_QUICK_READ:   state_ff <= nvspi_pkg::ST_ADDR;
                        default:                    state_ff <= nvspi_pkg::ST_IDLE;
                    endcase
                end
                nvspi_pkg::ST_ADDR: begin
                    if (acnt_ff == `NVSPI_ADDR_LAST) begin
                        unique case (cmd_ff)
                            nvspi_pkg::OP_WRITE:      state_ff <= nvspi_pkg::ST_WDATA;
                            nvspi_pkg::OP_QUICK_READ: state_ff <= nvspi_pkg::ST_DUMMY;
                            default:                  state_ff <= nvspi_pkg::ST_RDATA;
                        endcase
                    end
                end
                nvspi_pkg::ST_DUMMY:  state_ff <= nvspi_pkg::ST_RDATA;
                nvspi_pkg::ST_SWDATA: state_ff <= nvspi_pkg::ST_IDLE;
                default:              state_ff <= state_ff;
            endcase
        end
    end

    // opcode record and address byte count
    always_ff @(posedge clk_i) begin
        if (srst_i || cs_fall) begin
            cmd_ff  <= nvspi_pkg::OP_NONE;
            acnt_ff <= 2'h0;
        end else if (byte_done) begin
            if (state_ff == nvspi_pkg::ST_OPCODE) begin
                cmd_ff <= rx_byte;
            end
            if (state_ff == nvspi_pkg::ST_ADDR) begin
                acnt_ff <= acnt_ff + 1'b1;
            end
        end
    end

    // address register: top seven received bits fall off the end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            addr_ff <= '0;
        end else if (byte_done && state_ff == nvspi_pkg::ST_ADDR) begin
            addr_ff <= {addr_ff[ADDR_W-9:0], rx_byte};
        end else if (byte_done && state_ff == nvspi_pkg::ST_RDATA) begin
            addr_ff <= next_addr(addr_ff);
        end else if (push) begin
            addr_ff <= next_addr(addr_ff);
        end
    end

    // write latch: set by its command, cleared when a latch-clear, write or status write command ends
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            latch_ff <= 1'b0;
        end else if (byte_done && state_ff == nvspi_pkg::ST_OPCODE && rx_byte == nvspi_pkg::OP_LATCH_SET) begin
            latch_ff <= 1'b1;
        end else if (cs_rise && (cmd_ff == nvspi_pkg::OP_LATCH_CLEAR || cmd_ff == nvspi_pkg::OP_STATUS_WRITE
                                 || cmd_ff == nvspi_pkg::OP_WRITE)) begin
            latch_ff <= 1'b0;
        end
    end

    // nonvolatile guard bits: untouched by reset, only a permitted status write
    always_ff @(posedge clk_i) begin
        if (sr_write) begin
            block_guard_ff      <= {rx_byte[`NVSPI_SR_BG_HI_B], rx_byte[`NVSPI_SR_BG_LO_B]};
            pin_guard_enable_ff <= rx_byte[`NVSPI_SR_PIN_EN_B];
        end
    end

    // burst stop after a refused byte; overrun when the buffer is full
    always_ff @(posedge clk_i) begin
        if (srst_i || cs_fall) begin
            halt_ff    <= 1'b0;
            overrun_ff <= 1'b0;
        end else if (byte_done && state_ff == nvspi_pkg::ST_WDATA && !push) begin
            halt_ff    <= 1'b1;
            overrun_ff <= overrun_ff || (wr_ok && !fifo_in_ready);
        end
    end

    // read request into the array, answered one cycle later
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rd_pend_ff <= 1'b0;
            rd_ack_ff  <= 1'b0;
        end else begin
            rd_pend_ff <= byte_done && !cs_n_s && ((state_ff == nvspi_pkg::ST_ADDR && acnt_ff == `NVSPI_ADDR_LAST
                          && cmd_ff == nvspi_pkg::OP_READ) || state_ff == nvspi_pkg::ST_DUMMY
                          || state_ff == nvspi_pkg::ST_RDATA);
            rd_ack_ff  <= rd_pend_ff;
        end
    end

    // next outgoing byte: array data or status
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_buf_ff <= 8'h00;
        end else if (rd_ack_ff) begin
            tx_buf_ff <= mem_rdata;
        end else if (byte_done && state_ff == nvspi_pkg::ST_OPCODE) begin
            tx_buf_ff <= status;
        end
    end

    // output shifting on falling clock edges, released when deselected
    always_ff @(posedge clk_i) begin
        if (srst_i || cs_n_s) begin
            so_ff    <= 1'b0;
            so_oe_ff <= 1'b0;
            tx_sh_ff <= 8'h00;
        end else if (sck_fall && (state_ff == nvspi_pkg::ST_RDATA || state_ff == nvspi_pkg::ST_SRDATA)) begin
            so_oe_ff <= 1'b1;
            if (bitcnt_ff == 3'h0) begin
                so_ff    <= tx_buf_ff[7];
                tx_sh_ff <= {tx_buf_ff[6:0], 1'b0};
            end else begin
                so_ff    <= tx_sh_ff[7];
                tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
        end
    end

    assign spi_so_o     = so_ff;
    assign spi_so_oe_o  = so_oe_ff;
    assign wr_overrun_o = overrun_ff;

    // array port: reads win, buffered writes drain otherwise
    assign mem_en   = rd_pend_ff || fifo_out_valid;
    assign mem_we   = !rd_pend_ff && fifo_out_valid;
    assign mem_addr = rd_pend_ff ? addr_ff : fifo_out_data[FW-1:8];

    nvspi_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({addr_ff, rx_byte}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (!rd_pend_ff),
        .out_data_o  (fifo_out_data)
    );

    nvspi_mem #(
        .ADDR_W (ADDR_W)
    ) u_mem (
        .clk_i   (clk_i),
        .en_i    (mem_en),
        .we_i    (mem_we),
        .addr_i  (mem_addr),
        .wdata_i (fifo_out_data[7:0]),
        .rdata_o (mem_rdata)
    );

    // checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    chk_latch_clear: assert property (cs_rise && cmd_ff == nvspi_pkg::OP_LATCH_CLEAR |=> !latch_ff)
        else $error("latch not cleared after latch-clear command");
    chk_fixed_bits: assert property (
        byte_done && state_ff == nvspi_pkg::ST_OPCODE && rx_byte == nvspi_pkg::OP_STATUS_READ
        |=> tx_buf_ff[`NVSPI_SR_ONE_B] && !tx_buf_ff[`NVSPI_SR_ZERO_B] && tx_buf_ff[5:4] == 2'h0)
        else $error("status fixed bits wrong");
    chk_latch_only_cmd: assert property (
        $rose(latch_ff) |-> $past(byte_done) && $past(state_ff) == nvspi_pkg::ST_OPCODE
        && $past(rx_byte) == nvspi_pkg::OP_LATCH_SET)
        else $error("latch set outside its command");
    chk_guard_push: assert property (push |-> !guarded(block_guard_ff, addr_ff) && latch_ff)
        else $error("write pushed into guarded block or without latch");
    chk_pin_block: assert property (
        byte_done && state_ff == nvspi_pkg::ST_SWDATA && pin_guard_enable_ff && !wp_n_s
        |=> $stable(block_guard_ff) && $stable(pin_guard_enable_ff))
        else $error("status written while pin guard active");
    chk_sr_clear: assert property (cs_rise && cmd_ff == nvspi_pkg::OP_STATUS_WRITE |=> !latch_ff)
        else $error("latch survived status write");
    chk_eighth_bit: assert property (push |-> sck_rise && bitcnt_ff == 3'h7)
        else $error("byte committed before eighth bit");
    chk_addr_wrap: assert property (
        byte_done && state_ff == nvspi_pkg::ST_RDATA && addr_ff == `NVSPI_ADDR_MAX |=> addr_ff == `NVSPI_ADDR_ZERO)
        else $error("address did not wrap");
    chk_halt_hold: assert property (halt_ff && !cs_fall |=> !push)
        else $error("write after burst stop");
    chk_so_release: assert property (cs_n_s |=> !so_oe_ff ##1 !so_oe_ff)
        else $error("output driven while deselected");
    chk_rd_latency: assert property (rd_pend_ff |=> rd_ack_ff ##1 tx_buf_ff === $past(mem_rdata))
        else $error("read data not loaded in time");

    cov_status_write: cover property (sr_write);
    cov_read_wrap: cover property (byte_done && state_ff == nvspi_pkg::ST_RDATA && addr_ff == `NVSPI_ADDR_MAX);
    cov_quick_read: cover property (state_ff == nvspi_pkg::ST_DUMMY ##[1:300] state_ff == nvspi_pkg::ST_RDATA);
    cov_burst_halt: cover property ($rose(halt_ff));
endmodule

/* tb/nvspi_master.sv */
// spi master model, mode 0, eight clk_i cycles per sck half period
// assumes the bench resolves the released data-out line before so_i
`timescale 1ns/1ps
module nvspi_master (
    input  wire logic clk_i,
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i
);
    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end
    // select, then a setup gap before the first bit
    task automatic sel();
        @(posedge clk_i) cs_n_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    // release select; data-in then shows no stale bit
    task automatic desel();
        repeat (8) @(posedge clk_i);
        cs_n_o <= 1'b1;
        si_o   <= ~si_o;
        repeat (16) @(posedge clk_i);
    endtask
    // nb bits msb first: si set while sck low, so taken at rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int nb);
        for (int i = 7; i > 7 - nb; i--) begin
            si_o <= tx[i];
            repeat (8) @(posedge clk_i);
            sck_o <= 1'b1;
            rx[i] = so_i;
            repeat (8) @(posedge clk_i);
            sck_o <= 1'b0;
        end
    endtask
endmodule

/* tb/nvspi_core_tb.sv */
// self-checking bench for the serial memory slave
// assumes the master model in nvspi_master.sv
`timescale 1ns/1ps
module nvspi_core_tb;
    logic       clk_i   = 1'b0;
    logic       srst_i  = 1'b1;
    logic       guard_n = 1'b1;
    logic       sck, cs_n, si, so, oe, ovr;
    logic [7:0] rx;
    logic [7:0] wd[4];
    logic [7:0] rd[4];
    int         fail_count = 0;
    int         num_checks = 0;

    initial forever #5 clk_i = ~clk_i;

    nvspi_core nvspi_core_i (.clk_i(clk_i), .srst_i(srst_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
        .spi_si_i(si), .status_guard_n_i(guard_n), .spi_so_o(so), .spi_so_oe_o(oe), .wr_overrun_o(ovr));
    // released data-out reads high, since so is held at zero while not driven
    nvspi_master nvspi_master_i (.clk_i(clk_i), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(oe ? so : ~so));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic x(input logic [7:0] b);
        nvspi_master_i.xfer(b, rx, 8);
    endtask
    // single-byte command in its own select cycle
    task automatic op1(input logic [7:0] op);
        nvspi_master_i.sel();
        x(op);
        nvspi_master_i.desel();
    endtask
    // status read; junk on data-in during the answer
    task automatic sr(input logic [7:0] exp);
        nvspi_master_i.sel();
        x(nvspi_pkg::OP_STATUS_READ);
        x(8'hFF);
        nvspi_master_i.desel();
        check(rx, exp);
    endtask
    // latch set, then status write of v
    task automatic sw(input logic [7:0] v);
        op1(nvspi_pkg::OP_LATCH_SET);
        nvspi_master_i.sel();
        x(nvspi_pkg::OP_STATUS_WRITE);
        x(v);
        nvspi_master_i.desel();
    endtask
    // opcode, address, dummy for quick read, n data bytes, last one nb bits
    task automatic mem(input logic [7:0] op, input logic [16:0] a, input int n, input int nb);
        nvspi_master_i.sel();
        x(op);
        x({7'h7F, a[16]});
        x(a[15:8]);
        x(a[7:0]);
        if (op == nvspi_pkg::OP_QUICK_READ) x(8'h00);
        for (int k = 0; k < n; k++) nvspi_master_i.xfer(wd[k], rd[k], (k == n - 1) ? nb : 8);
        nvspi_master_i.desel();
    endtask
    task automatic do_reset();
        @(posedge clk_i) srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // latch flag and status write of every bit
    task automatic t_latch();
        sr(8'h40);
        op1(nvspi_pkg::OP_LATCH_SET);
        sr(8'h42);
        sw(8'hFF);
        sr(8'hCC);
        sw(8'h00);
        sr(8'h40);
        op1(nvspi_pkg::OP_LATCH_SET);
        op1(nvspi_pkg::OP_LATCH_CLEAR);
        sr(8'h40);
    endtask
    // burst across the wrap, refused and partial writes
    task automatic t_write();
        wd = '{8'h11, 8'h22, 8'h00, 8'h00};
        op1(nvspi_pkg::OP_LATCH_SET);
        mem(nvspi_pkg::OP_WRITE, 17'h1FFFF, 2, 8);
        sr(8'h40);
        wd[0] = 8'h55;
        mem(nvspi_pkg::OP_WRITE, 17'h1FFFF, 1, 8);
        wd[0] = 8'h66;
        op1(nvspi_pkg::OP_LATCH_SET);
        mem(nvspi_pkg::OP_WRITE, 17'h00000, 1, 4);
        wd = '{8'hFF, 8'hFF, 8'h00, 8'h00};
        mem(nvspi_pkg::OP_READ, 17'h1FFFF, 2, 8);
        check(rd[0], 8'h11);
        check(rd[1], 8'h22);
        check({oe, ovr}, 2'h0);
    endtask
    // quarter guard, burst stop, pin guard and persistence
    task automatic t_guard();
        wd = '{8'h11, 8'h22, 8'h00, 8'h00};
        op1(nvspi_pkg::OP_LATCH_SET);
        mem(nvspi_pkg::OP_WRITE, 17'h17FFF, 2, 8);
        sw(8'h84);
        wd = '{8'h33, 8'h44, 8'h55, 8'h00};
        op1(nvspi_pkg::OP_LATCH_SET);
        mem(nvspi_pkg::OP_WRITE, 17'h17FFF, 3, 8);
        mem(nvspi_pkg::OP_QUICK_READ, 17'h17FFF, 2, 8);
        check(rd[0], 8'h33);
        check(rd[1], 8'h22);
        @(posedge clk_i) guard_n <= 1'b0;
        sw(8'h00);
        sr(8'hC4);
        wd[0] = 8'h77;
        op1(nvspi_pkg::OP_LATCH_SET);
        mem(nvspi_pkg::OP_WRITE, 17'h00010, 1, 8);
        mem(nvspi_pkg::OP_READ, 17'h00010, 1, 8);
        check(rd[0], 8'h77);
        do_reset();
        sr(8'hC4);
        @(posedge clk_i) guard_n <= 1'b1;
        sw(8'h00);
        sr(8'h40);
    endtask

    // watchdog against a hung run
    initial begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_latch();
        t_write();
        t_guard();
        print_verdict();
    end
endmodule
